// [design/fpc_pkg.sv]
// constants shared by the floppy power setup configuration bank
package fpc_pkg;
   localparam logic [7:0] FPC_IDX_FLOPPY_SETUP  = 8'h05;
   localparam logic [7:0] FPC_IDX_DRIVE_TYPES   = 8'h06;
   localparam logic [7:0] FPC_IDX_PDN_BOOT      = 8'h07;
   localparam logic [7:0] FPC_RST_FLOPPY_SETUP  = 8'h00;
   localparam logic [7:0] FPC_RST_DRIVE_TYPES   = 8'hff;
   localparam logic [7:0] FPC_RST_PDN_BOOT      = 8'h00;
   localparam logic [7:0] FPC_RST_INDEX         = 8'h00;
   localparam logic [7:0] FPC_WMASK_SETUP       = 8'h1f;
   localparam logic [7:0] FPC_WMASK_PDN_BOOT    = 8'hf3;
   localparam int         FPC_BIT_PUSH_PULL     = 0;
   localparam int         FPC_BIT_TRISTATE      = 1;
   localparam int         FPC_BIT_NON_BURST     = 2;
   localparam int         FPC_DENSITY_SELECT_FIELD_LSB        = 3;
   localparam int         FPC_BIT_PDN_PARALLEL  = 4;
   localparam int         FPC_BIT_PDN_UART2     = 5;
   localparam int         FPC_BIT_PDN_UART1     = 6;
   localparam int         FPC_BIT_PDN_FLOPPY    = 7;
   localparam logic [1:0] FPC_DENSITY_SELECT_FIELD_NORMAL     = 2'h0;
   localparam logic [1:0] FPC_DENSITY_SELECT_FIELD_FORCE_ONE  = 2'h2;
   localparam logic [1:0] FPC_DENSITY_SELECT_FIELD_FORCE_ZERO = 2'h3;
   localparam logic [1:0] FPC_PP_ECP_EPP        = 2'h3;
   localparam logic [2:0] FPC_ECR_MODE_SPP      = 3'h0;
   localparam logic [2:0] FPC_ECR_MODE_EPP      = 3'h4;
   localparam int         FPC_FDC_PINS          = 8;
   localparam int         FPC_SYS_CLK_HZ        = 20_000_000;
   localparam int         FPC_MIDI_CLK_HZ       = 125_000;
   localparam int         FPC_MIDI_DIV_CYCLES   = FPC_SYS_CLK_HZ / FPC_MIDI_CLK_HZ;
   localparam logic [7:0] FPC_MIDI_DIV_LAST     = 8'(FPC_MIDI_DIV_CYCLES - 1);
endpackage : fpc_pkg

// [design/fpc_midi_divider.sv]
// midi rate enable divider, one tick per 125 khz period
`timescale 1ns/1ps
`default_nettype none
module fpc_midi_divider
   import fpc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic enable,
   output var  logic tick_q
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       tick_d;

   always_comb
   begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (!enable)
      begin
         cnt_d = 8'h00;
      end
      else if (cnt_q == FPC_MIDI_DIV_LAST)
      begin
         cnt_d  = 8'h00;
         tick_d = 1'b1;
      end
      else
      begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end
endmodule : fpc_midi_divider
`default_nettype wire

// [design/fpc_config_bank.sv]
// floppy setup, drive type and power-down configuration bank
`timescale 1ns/1ps
`default_nettype none
module fpc_config_bank
   import fpc_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    cfg_mode,
   input  wire logic                    idx_wr,
   input  wire logic                    data_wr,
   input  wire logic                    data_rd,
   input  wire logic [7:0]              wdata,
   output var  logic [7:0]              rdata_q,
   output var  logic                    rd_valid_q,
   input  wire logic [FPC_FDC_PINS-1:0] fdc_pin_val,
   input  wire logic                    density1_func,
   input  wire logic                    density1_force_high_bit,
   input  wire logic                    density_select_field_func,
   input  wire logic                    fdc_drq,
   input  wire logic                    fdc_irq,
   input  wire logic                    fdc_byte_ack,
   input  wire logic                    fifo_en,
   input  wire logic [FPC_FDC_PINS-1:0] pp_fdc_val,
   input  wire logic [1:0]              pp_ext_mode,
   input  wire logic [2:0]              ecr_mode,
   input  wire logic                    midi1_en,
   input  wire logic                    midi2_en,
   output var  logic [FPC_FDC_PINS-1:0] fdc_pin_out,
   output var  logic [FPC_FDC_PINS-1:0] fdc_pin_oe,
   output var  logic                    density_out_one,
   output var  logic                    density_out_one_oe,
   output var  logic                    density_select_field_out,
   output var  logic                    density_select_field_oe,
   output var  logic                    floppy_dma_request,
   output var  logic                    floppy_irq_line,
   output var  logic [FPC_FDC_PINS-1:0] pp_fdc_out,
   output var  logic [FPC_FDC_PINS-1:0] pp_fdc_oe,
   output var  logic [7:0]              drive_type_ids,
   output var  logic [1:0]              boot_drive,
   output var  logic [3:0]              pdn_enable,
   output var  logic                    epp_select,
   output var  logic                    spp_select,
   output var  logic                    midi1_tick,
   output var  logic                    midi2_tick
);
   // one data register write with its mask, used by the setup and power-down/boot registers
   function automatic logic [7:0] masked_write(input logic [7:0] old_v,
                                               input logic [7:0] new_v,
                                               input logic [7:0] mask);
      masked_write = (old_v & ~mask) | (new_v & mask);
   endfunction : masked_write

   // open drain drives only the low level, so a high is released
   function automatic logic pin_oe(input logic val,
                                   input logic push_pull,
                                   input logic tri_all);
      pin_oe = !tri_all && (push_pull || !val);
   endfunction : pin_oe

   logic [7:0] config_index_reg_q;
   logic [7:0] config_index_reg_d;
   logic [7:0] floppy_setup_q;
   logic [7:0] floppy_setup_d;
   logic [7:0] drive_type_ids_q;
   logic [7:0] drive_type_ids_d;
   logic [7:0] power_down_boot_select_q;
   logic [7:0] power_down_boot_select_d;
   logic [7:0] rdata_d;
   logic       rd_valid_d;

   // register bank
   always_comb
   begin
      config_index_reg_d       = config_index_reg_q;
      floppy_setup_d           = floppy_setup_q;
      drive_type_ids_d         = drive_type_ids_q;
      power_down_boot_select_d = power_down_boot_select_q;
      rdata_d                  = rdata_q;
      rd_valid_d               = 1'b0;
      if (cfg_mode)
      begin
         if (idx_wr)
         begin
            config_index_reg_d = wdata;
         end
         if (data_wr)
         begin
            case (config_index_reg_q)
               FPC_IDX_FLOPPY_SETUP:
                  floppy_setup_d = masked_write(floppy_setup_q, wdata, FPC_WMASK_SETUP);
               FPC_IDX_DRIVE_TYPES:
                  drive_type_ids_d = wdata;
               FPC_IDX_PDN_BOOT:
                  power_down_boot_select_d = masked_write(power_down_boot_select_q, wdata,
                                                          FPC_WMASK_PDN_BOOT);
               default:
                  floppy_setup_d = floppy_setup_q;
            endcase
         end
         if (data_rd)
         begin
            rd_valid_d = 1'b1;
            case (config_index_reg_q)
               FPC_IDX_FLOPPY_SETUP: rdata_d = floppy_setup_q;
               FPC_IDX_DRIVE_TYPES:  rdata_d = drive_type_ids_q;
               FPC_IDX_PDN_BOOT:     rdata_d = power_down_boot_select_q;
               default:              rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         config_index_reg_q       <= FPC_RST_INDEX;
         floppy_setup_q           <= FPC_RST_FLOPPY_SETUP;
         drive_type_ids_q         <= FPC_RST_DRIVE_TYPES;
         power_down_boot_select_q <= FPC_RST_PDN_BOOT;
         rdata_q                  <= 8'h00;
         rd_valid_q               <= 1'b0;
      end
      else
      begin
         config_index_reg_q       <= config_index_reg_d;
         floppy_setup_q           <= floppy_setup_d;
         drive_type_ids_q         <= drive_type_ids_d;
         power_down_boot_select_q <= power_down_boot_select_d;
         rdata_q                  <= rdata_d;
         rd_valid_q               <= rd_valid_d;
      end
   end

   // pin drivers and configuration outputs
   logic                    push_pull;
   logic                    tri_all;
   logic                    non_burst;
   logic [1:0]              density_select_field_mode;
   logic [FPC_FDC_PINS-1:0] fdc_pin_out_d;
   logic [FPC_FDC_PINS-1:0] fdc_pin_oe_d;
   logic                    density_out_one_d;
   logic                    density_out_one_oe_d;
   logic                    density_select_field_val;
   logic                    density_select_field_out_d;
   logic                    density_select_field_oe_d;
   logic                    strobe_gap;
   logic                    floppy_dma_request_d;
   logic                    floppy_irq_line_d;
   logic                    epp_select_d;
   logic                    spp_select_d;
   logic [3:0]              pdn_enable_d;

   always_comb
   begin
      push_pull   = floppy_setup_q[FPC_BIT_PUSH_PULL];
      tri_all     = floppy_setup_q[FPC_BIT_TRISTATE];
      non_burst   = floppy_setup_q[FPC_BIT_NON_BURST];
      density_select_field_mode = floppy_setup_q[FPC_DENSITY_SELECT_FIELD_LSB +: 2];
      for (int i = 0; i < FPC_FDC_PINS; i++)
      begin
         fdc_pin_out_d[i] = push_pull ? fdc_pin_val[i] : 1'b0;
         fdc_pin_oe_d[i]  = pin_oe(fdc_pin_val[i], push_pull, tri_all);
      end
      // force-high wins over the programmed value, tri-state wins over both
      density_out_one_d    = density1_force_high_bit ? 1'b1 : density1_func;
      density_out_one_oe_d = pin_oe(density_out_one_d, push_pull, tri_all);
      if (!push_pull)
      begin
         density_out_one_d = 1'b0;
      end
      case (density_select_field_mode)
         FPC_DENSITY_SELECT_FIELD_FORCE_ONE:  density_select_field_val = 1'b1;
         FPC_DENSITY_SELECT_FIELD_FORCE_ZERO: density_select_field_val = 1'b0;
         default:               density_select_field_val = density_select_field_func;
      endcase
      density_select_field_out_d = push_pull ? density_select_field_val : 1'b0;
      density_select_field_oe_d  = pin_oe(density_select_field_val, push_pull, tri_all);
      // in non-burst mode with the fifo on, a one-cycle low after each byte makes a strobe per transfer
      strobe_gap           = non_burst && fifo_en && fdc_byte_ack;
      floppy_dma_request_d = fdc_drq && !strobe_gap;
      floppy_irq_line_d    = fdc_irq && !strobe_gap;
      epp_select_d = (pp_ext_mode == FPC_PP_ECP_EPP) && (ecr_mode == FPC_ECR_MODE_EPP);
      spp_select_d = pp_ext_mode[1] && (ecr_mode == FPC_ECR_MODE_SPP);
      pdn_enable_d = power_down_boot_select_q[FPC_BIT_PDN_FLOPPY:FPC_BIT_PDN_PARALLEL];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         fdc_pin_out        <= '0;
         fdc_pin_oe         <= '0;
         density_out_one    <= 1'b0;
         density_out_one_oe <= 1'b0;
         density_select_field_out         <= 1'b0;
         density_select_field_oe          <= 1'b0;
         floppy_dma_request <= 1'b0;
         floppy_irq_line    <= 1'b0;
         pp_fdc_out         <= '0;
         pp_fdc_oe          <= '0;
         drive_type_ids     <= FPC_RST_DRIVE_TYPES;
         boot_drive         <= 2'h0;
         pdn_enable         <= 4'h0;
         epp_select         <= 1'b0;
         spp_select         <= 1'b0;
      end
      else
      begin
         fdc_pin_out        <= fdc_pin_out_d;
         fdc_pin_oe         <= fdc_pin_oe_d;
         density_out_one    <= density_out_one_d;
         density_out_one_oe <= density_out_one_oe_d;
         density_select_field_out         <= density_select_field_out_d;
         density_select_field_oe          <= density_select_field_oe_d;
         floppy_dma_request <= floppy_dma_request_d;
         floppy_irq_line    <= floppy_irq_line_d;
         pp_fdc_out         <= pp_fdc_val;
         pp_fdc_oe          <= '1;
         drive_type_ids     <= drive_type_ids_q;
         boot_drive         <= power_down_boot_select_q[1:0];
         pdn_enable         <= pdn_enable_d;
         epp_select         <= epp_select_d;
         spp_select         <= spp_select_d;
      end
   end

   fpc_midi_divider u_midi1
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .enable  (midi1_en),
      .tick_q  (midi1_tick)
   );

   fpc_midi_divider u_midi2
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .enable  (midi2_en),
      .tick_q  (midi2_tick)
   );

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence setup_write_s;
      cfg_mode && data_wr && (config_index_reg_q == FPC_IDX_FLOPPY_SETUP);
   endsequence

   sequence byte_strobe_s;
      non_burst && fifo_en && fdc_byte_ack;
   endsequence

   setup_write_a: assert property (setup_write_s |=> floppy_setup_q == {3'h0, $past(wdata[4:0])})
      else $error("floppy setup write not stored");
   no_access_a: assert property (!cfg_mode |=> $stable(floppy_setup_q) && $stable(config_index_reg_q))
      else $error("register changed outside config state");
   rsvd_zero_a: assert property (floppy_setup_q[7:5] == 3'h0 && power_down_boot_select_q[3:2] == 2'h0)
      else $error("reserved bits not zero");
   open_drain_a: assert property (!push_pull |=> fdc_pin_out == '0)
      else $error("open drain pin drove high");
   tri_all_a: assert property (tri_all |=> fdc_pin_oe == '0 && !density_out_one_oe && !density_select_field_oe)
      else $error("floppy pin driven in tri-state");
   force_high_a: assert property (!tri_all && push_pull && density1_force_high_bit
                                  |=> density_out_one && density_out_one_oe)
      else $error("density pin not forced high");
   tri_force_a: assert property (tri_all && density1_force_high_bit |=> !density_out_one_oe)
      else $error("force high overrode tri-state");
   density_select_field_one_a: assert property (density_select_field_mode == FPC_DENSITY_SELECT_FIELD_FORCE_ONE && push_pull && !tri_all
                                  |=> density_select_field_out && density_select_field_oe)
      else $error("density select not forced to one");
   strobe_gap_a: assert property (byte_strobe_s |=> !floppy_dma_request && !floppy_irq_line)
      else $error("no strobe gap after byte");
   type_read_a: assert property (cfg_mode && data_rd && config_index_reg_q == FPC_IDX_DRIVE_TYPES
                                 |=> rd_valid_q && rdata_q == $past(drive_type_ids_q))
      else $error("drive type read wrong");
   // the first edge after reset still shows the reset outputs, so wait one edge
   pp_route_a: assert property ($past(rst_n) |-> pp_fdc_oe == '1 && pp_fdc_out == $past(pp_fdc_val))
      else $error("parallel floppy pins gated by setup");
   midi_tick_a: assert property (midi1_tick |=> !midi1_tick [*8])
      else $error("midi tick too frequent");
   density_select_field_zero_a: assert property (density_select_field_mode == FPC_DENSITY_SELECT_FIELD_FORCE_ZERO && !tri_all
                                   |=> !density_select_field_out && density_select_field_oe)
      else $error("density select not forced to zero");
   dens_prog_a: assert property (!tri_all && push_pull && !density1_force_high_bit
                                 |=> density_out_one == $past(density1_func))
      else $error("density pin lost programmed value");
   od_enable_a: assert property (!push_pull && !tri_all |=> fdc_pin_oe == ~$past(fdc_pin_val))
      else $error("open drain pin enable wrong");
   pdn_map_a: assert property (pdn_enable ==
                               $past(power_down_boot_select_q[FPC_BIT_PDN_FLOPPY:FPC_BIT_PDN_PARALLEL]))
      else $error("power-down enables not mapped");
   boot_map_a: assert property (boot_drive == $past(power_down_boot_select_q[1:0]))
      else $error("boot drive not mapped");
   no_read_a: assert property (!cfg_mode |=> !rd_valid_q)
      else $error("read answered outside config state");
   types_write_a: assert property (cfg_mode && data_wr && config_index_reg_q == FPC_IDX_DRIVE_TYPES
                                   |=> drive_type_ids_q == $past(wdata))
      else $error("drive type write not stored");
   burst_keep_a: assert property (!non_burst && fdc_drq |=> floppy_dma_request)
      else $error("request gapped in burst mode");
endmodule : fpc_config_bank
`default_nettype wire

// [tb/fpc_host_model.sv]
// host software model driving the configuration register port
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] rdata_q,
   input  wire logic       rd_valid_q,
   output var  logic       idx_wr,
   output var  logic       data_wr,
   output var  logic       data_rd,
   output var  logic [7:0] wdata
);
   logic       rv;
   logic [7:0] rd;

   initial
   begin
      idx_wr = 1'b0;
      data_wr = 1'b0;
      data_rd = 1'b0;
      wdata = 8'h00;
      rv = 1'b0;
      rd = 8'h00;
   end

   // one strobe per call; software loads the index before every data access
   task automatic cyc(input logic iw, input logic dw, input logic dr, input logic [7:0] d);
      @(posedge sys_clk);
      #2;
      idx_wr = iw;
      data_wr = dw;
      data_rd = dr;
      wdata = d;
      @(posedge sys_clk);
      #2;
      idx_wr = 1'b0;
      data_wr = 1'b0;
      data_rd = 1'b0;
      // released data bus must not keep showing the last byte
      wdata = ~d;
      rv = rd_valid_q;
      rd = rdata_q;
   endtask : cyc
endmodule : fpc_host_model
`default_nettype wire

// [tb/floppy_power_setup_config_bench.sv]
// self-checking bench for the floppy setup configuration bank
`timescale 1ns/1ps
`default_nettype none
module floppy_power_setup_config_bench;
   import fpc_pkg::*;
   logic       sys_clk, rst_n, cfg_mode, density1_func, density1_force_high_bit, density_select_field_func;
   logic       fdc_drq, fdc_irq, fdc_byte_ack, fifo_en, midi1_en, midi2_en;
   logic       idx_wr, data_wr, data_rd, rd_valid_q, epp_select, spp_select, midi1_tick, midi2_tick;
   logic       density_out_one, density_out_one_oe, density_select_field_out, density_select_field_oe, floppy_dma_request, floppy_irq_line;
   logic [7:0] wdata, rdata_q, fdc_pin_val, pp_fdc_val, fdc_pin_out, fdc_pin_oe, pp_fdc_out, pp_fdc_oe;
   logic [7:0] drive_type_ids;
   logic [1:0] pp_ext_mode, boot_drive;
   logic [2:0] ecr_mode;
   logic [3:0] pdn_enable;
   int         miscompares = 0;
   int         check_count = 0;
   int         n1, n2;
   logic [7:0] s;

   fpc_config_bank i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_mode(cfg_mode), .idx_wr(idx_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata_q(rdata_q), .rd_valid_q(rd_valid_q),
      .fdc_pin_val(fdc_pin_val), .density1_func(density1_func), .density1_force_high_bit(density1_force_high_bit),
      .density_select_field_func(density_select_field_func), .fdc_drq(fdc_drq), .fdc_irq(fdc_irq), .fdc_byte_ack(fdc_byte_ack),
      .fifo_en(fifo_en), .pp_fdc_val(pp_fdc_val), .pp_ext_mode(pp_ext_mode), .ecr_mode(ecr_mode),
      .midi1_en(midi1_en), .midi2_en(midi2_en), .fdc_pin_out(fdc_pin_out), .fdc_pin_oe(fdc_pin_oe),
      .density_out_one(density_out_one), .density_out_one_oe(density_out_one_oe), .density_select_field_out(density_select_field_out),
      .density_select_field_oe(density_select_field_oe), .floppy_dma_request(floppy_dma_request), .floppy_irq_line(floppy_irq_line),
      .pp_fdc_out(pp_fdc_out), .pp_fdc_oe(pp_fdc_oe), .drive_type_ids(drive_type_ids), .boot_drive(boot_drive),
      .pdn_enable(pdn_enable), .epp_select(epp_select), .spp_select(spp_select), .midi1_tick(midi1_tick),
      .midi2_tick(midi2_tick));

   fpc_host_model i_host (.sys_clk(sys_clk), .rdata_q(rdata_q), .rd_valid_q(rd_valid_q), .idx_wr(idx_wr),
      .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata));

   always #25 sys_clk = ~sys_clk;

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      i_host.cyc(1'b1, 1'b0, 1'b0, idx);
      i_host.cyc(1'b0, 1'b1, 1'b0, v);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
      i_host.cyc(1'b1, 1'b0, 1'b0, idx);
      i_host.cyc(1'b0, 1'b0, 1'b1, 8'h00);
      chk({nm, " valid"}, {7'h00, i_host.rv}, 8'h01);
      chk(nm, i_host.rd, exp);
   endtask : rd

   task automatic step;
      @(posedge sys_clk);
      #2;
   endtask : step

   task automatic do_reset;
      rst_n = 1'b0;
      repeat (5) @(posedge sys_clk);
      #2;
      rst_n = 1'b1;
   endtask : do_reset

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   initial
   begin
      #500000;
      miscompares++;
      close_out();
   end

   initial
   begin
      {sys_clk, cfg_mode, density1_func, density1_force_high_bit, density_select_field_func} = 5'h0a;
      {fdc_drq, fdc_irq, fdc_byte_ack, fifo_en, midi1_en, midi2_en} = 6'h00;
      {pp_ext_mode, ecr_mode} = 5'h00;
      fdc_pin_val = 8'ha5;
      pp_fdc_val = 8'h3c;
      do_reset();
      rd(8'h05, 8'h00, "setup reset");
      rd(8'h06, 8'hff, "types reset");
      rd(8'h07, 8'h00, "pdn reset");
      rd(8'h0b, 8'h00, "unmapped");
      wr(8'h05, 8'hff);
      rd(8'h05, 8'h1f, "setup reserved");
      wr(8'h07, 8'hff);
      rd(8'h07, 8'hf3, "pdn reserved");
      for (int i = 4; i < 8; i++)
      begin
         wr(8'h07, 8'h01 | (8'h01 << i));
         step();
         chk("pdn_enable", {4'h0, pdn_enable}, 8'h01 << (i - 4));
         chk("boot_drive", {6'h00, boot_drive}, 8'h01);
      end
      wr(8'h06, 8'h1b);
      step();
      chk("drive_type_ids", drive_type_ids, 8'h1b);
      // accesses outside configuration state must leave everything alone
      cfg_mode = 1'b0;
      wr(8'h06, 8'h00);
      cfg_mode = 1'b1;
      rd(8'h06, 8'h1b, "types locked");
      // open drain, push-pull, tri-state with density forced high
      for (int k = 0; k < 3; k++)
      begin
         s = 8'(k);
         wr(8'h05, s);
         step();
         chk("pin_oe", fdc_pin_oe, s[1] ? 8'h00 : (s[0] ? 8'hff : 8'h5a));
         if (!s[1])
            chk("pin_out", fdc_pin_out, s[0] ? 8'ha5 : 8'h00);
         chk("pp_out", pp_fdc_out, 8'h3c);
         chk("pp_oe", pp_fdc_oe, 8'hff);
         chk("dens1_oe", {7'h00, density_out_one_oe}, {7'h00, s == 8'h01});
         if (s == 8'h01)
            chk("dens1", {7'h00, density_out_one}, 8'h01);
         chk("density_select_field_oe", {7'h00, density_select_field_oe}, {7'h00, !s[1]});
      end
      density1_force_high_bit = 1'b0;
      wr(8'h05, 8'h01);
      step();
      chk("dens1 programmed", {7'h00, density_out_one}, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         density_select_field_func = k[2];
         wr(8'h05, {3'h0, k[1:0], 3'h1});
         step();
         chk("density_select_field", {7'h00, density_select_field_out}, {7'h00, k[1:0] == 2'h2 || (k[1:0] != 2'h3 && k[2])});
      end
      {fdc_drq, fdc_irq, fifo_en} = 3'h7;
      for (int nb = 0; nb < 2; nb++)
      begin
         wr(8'h05, 8'h01 | 8'(nb << 2));
         step();
         chk("drq idle", {6'h00, floppy_dma_request, floppy_irq_line}, 8'h03);
         fdc_byte_ack = 1'b1;
         step();
         fdc_byte_ack = 1'b0;
         chk("drq strobe", {6'h00, floppy_dma_request, floppy_irq_line}, nb ? 8'h00 : 8'h03);
      end
      for (int k = 0; k < 8; k++)
      begin
         pp_ext_mode = k[1:0];
         ecr_mode = k[2] ? FPC_ECR_MODE_EPP : FPC_ECR_MODE_SPP;
         step();
         step();
         chk("epp", {7'h00, epp_select}, {7'h00, k == 7});
         chk("spp", {7'h00, spp_select}, {7'h00, k[1] && !k[2]});
      end
      for (int k = 0; k < 2; k++)
      begin
         {midi1_en, midi2_en} = k ? 2'b01 : 2'b10;
         n1 = 0;
         n2 = 0;
         repeat (2 * FPC_MIDI_DIV_CYCLES)
         begin
            step();
            n1 += midi1_tick;
            n2 += midi2_tick;
         end
         chk("midi ticks", 8'(n1 + 2 * n2), k ? 8'h04 : 8'h02);
      end
      do_reset();
      chk("pdn after reset", {4'h0, pdn_enable}, 8'h00);
      rd(8'h07, 8'h00, "pdn rereset");
      rd(8'h05, 8'h00, "setup rereset");
      close_out();
   end
endmodule : floppy_power_setup_config_bench
`default_nettype wire
